//--- design/sdc_col_gen.v
`timescale 1ns/1ns
`include "sdc_consts.vh"
// ************************************************************
// burst column generator: start column plus step count
// ************************************************************
module sdc_col_gen (
  // burst setup
  input  wire [10:0] start_col,
  input  wire [2:0]  burst_len,
  input  wire        burst_order_bit,
  input  wire [10:0] step,
  // result
  output reg  [10:0] col
);
  reg [2:0]  low_mask;  // wrap field width
  reg [2:0]  seq_low;   // sequential low bits
  reg [2:0]  ilv_low;   // interleaved low bits
  reg [2:0]  low;

  // pick the block width and combine the start with the step
  always @* begin
    low_mask = 3'h0;
    seq_low  = start_col[2:0] + step[2:0];
    ilv_low  = start_col[2:0] ^ step[2:0];
    col      = start_col;
    case (burst_len)
      `SDC_BL_2: low_mask = 3'h1;
      `SDC_BL_4: low_mask = 3'h3;
      `SDC_BL_8: low_mask = 3'h7;
      default:   low_mask = 3'h0;
    endcase
    // burst of one ignores the order bit and keeps its column
    low = burst_order_bit ? ilv_low : seq_low;
    if (burst_len == `SDC_BL_PAGE) begin
      col = start_col + step;                                  // wraps in 2048
    end else begin
      col = (start_col & ~{8'h00, low_mask}) | ({8'h00, low} & {8'h00, low_mask});
    end
  end
endmodule // sdc_col_gen

//--- design/sdc_consts.vh
`ifndef SDC_CONSTS_VH
`define SDC_CONSTS_VH
// ************************************************************
// command codes on row, column, write strobes
// ************************************************************
`define SDC_CMD_ACTIVATE   3'h3
`define SDC_CMD_READ       3'h5
`define SDC_CMD_WRITE      3'h4
`define SDC_CMD_TERMINATE  3'h6
`define SDC_CMD_PRECHARGE  3'h2
`define SDC_CMD_REFRESH    3'h1
`define SDC_CMD_MODE_LOAD  3'h0
`define SDC_CMD_NOP        3'h7
// ************************************************************
// mode word field positions
// ************************************************************
`define SDC_BL_LSB         0
`define SDC_BL_MSB         2
`define SDC_ORDER_BIT      3
`define SDC_LAT_LSB        4
`define SDC_LAT_MSB        6
`define SDC_OPM_LO_BIT     7
`define SDC_OPM_HI_BIT     8
`define SDC_WSINGLE_BIT    9
`define SDC_AP_BIT         10
// ************************************************************
// field encodings and reset values
// ************************************************************
`define SDC_BL_1           3'h0
`define SDC_BL_2           3'h1
`define SDC_BL_4           3'h2
`define SDC_BL_8           3'h3
`define SDC_BL_PAGE        3'h7
`define SDC_LAT_2          3'h2
`define SDC_LAT_3          3'h3
`define SDC_MODE_RESET     12'h020
`define SDC_PAGE_COLS      2048
`define SDC_BANKS          4
`endif

//--- design/sdc_fifo.v
`timescale 1ns/1ns
// ************************************************************
// fifo: parameterised width and depth, valid/ready both sides
// ************************************************************
module sdc_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];  // storage
  reg [AW-1:0]    wr_ptr;           // write index
  reg [AW-1:0]    rd_ptr;           // read index
  reg [AW:0]      count;            // occupancy
  wire            push;
  wire            pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage has no reset; only pointers and count carry control state
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and occupancy
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sdc_fifo

//--- design/sdc_top.v
`timescale 1ns/1ns
`include "sdc_consts.vh"
// Function
// - drive from n+m-1, valid at n+m; here drive and data start on the same edge
// - latency two or three clocks only
// - sequential or interleaved column ordering
// - low column bits start, wrap in block
// - full page wraps within 2048 columns
// - burst one ignores order bit
// - write single bit limits writes to one
// - deselected cycles register no command
// - no-operation leaves operations undisturbed
// - decode strobes into seven commands
// - activate opens row in bank
// - read column, optional auto precharge
// - write column, optional auto precharge
// - read mask high gives high-z later
// - mode word field layout
// - precharge one bank or all
// - write mask high keeps byte unchanged
// - refresh is auto or self by gate
module sdc_top #(
  parameter DW = 32,   // data width
  parameter MW = 4     // byte mask width
) (
  // clock and reset
  input  wire          CORE_CLK,
  input  wire          RESET_N,
  // command pins
  input  wire          CS_N,
  input  wire          RAS_N,
  input  wire          CAS_N,
  input  wire          WE_N,
  input  wire          CKE,
  input  wire [12:0]   ADDR,
  input  wire          BANK_SELECT_LO,
  input  wire          BANK_SELECT_HI,
  input  wire [MW-1:0] DQM,
  // data pins as three signals
  input  wire [DW-1:0] DQ_IN,
  output reg  [DW-1:0] DQ_OUT,
  output reg  [DW-1:0] DQ_OE,
  // array side: read data stream in through a fifo
  input  wire          ARR_RD_VALID,
  output reg           ARR_RD_READY,
  input  wire [DW-1:0] ARR_RD_DATA,
  // array side: access strobes
  output reg           ARR_READ,
  output reg           ARR_WRITE,
  output reg  [1:0]    ARR_BANK,
  output reg  [12:0]   ARR_ROW,
  output reg  [10:0]   ARR_COL,
  output reg  [DW-1:0] ARR_WDATA,
  output reg  [MW-1:0] ARR_BYTE_EN,
  // status
  output reg  [3:0]    ROW_OPEN,
  output reg           AUTO_REFRESH,
  output reg           SELF_REFRESH,
  output reg  [11:0]   MODE_WORD,
  output reg           LATENCY_BAD
);
  localparam BW = DW / MW;             // bits per byte lane
  localparam ST_IDLE  = 2'h0;          // no burst
  localparam ST_READ  = 2'h1;          // read burst
  localparam ST_WRITE = 2'h2;          // write burst

  // ************************************************************
  // reset release and pin synchronisers
  // ************************************************************
  reg        rst_s1, rst_s2;           // reset release chain
  wire       rst_n = rst_s2;
  reg [22+DW+MW-1:0] pin_s1;           // first stage, read by pin_s2 only
  reg [22+DW+MW-1:0] pin_s2;           // synchronised pins

  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // pins pass two flops; the controller sees a fixed two-cycle skew
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= {(22+DW+MW){1'b1}};
      pin_s2 <= {(22+DW+MW){1'b1}};
    end else begin
      pin_s1 <= {CS_N, RAS_N, CAS_N, WE_N, CKE, ADDR, BANK_SELECT_HI, BANK_SELECT_LO, DQM, DQ_IN, 2'h3};
      pin_s2 <= pin_s1;
    end
  end

  wire          s_cs_n = pin_s2[22+DW+MW-1];
  wire [2:0]    s_cmd  = pin_s2[22+DW+MW-2 -: 3];
  wire          s_cke  = pin_s2[22+DW+MW-5];
  wire [12:0]   s_addr = pin_s2[22+DW+MW-6 -: 13];
  wire [1:0]    s_bank = pin_s2[DW+MW+3 -: 2];
  wire [MW-1:0] s_dqm  = pin_s2[DW+MW+1 -: MW];
  wire [DW-1:0] s_dq   = pin_s2[DW+1 -: DW];

  // ************************************************************
  // command decode
  // ************************************************************
  // deselect registers nothing; nop decodes to no action
  wire sel     = ~s_cs_n;
  wire is_act  = sel & (s_cmd == `SDC_CMD_ACTIVATE);
  wire is_rd   = sel & (s_cmd == `SDC_CMD_READ);
  wire is_wr   = sel & (s_cmd == `SDC_CMD_WRITE);
  wire is_term = sel & (s_cmd == `SDC_CMD_TERMINATE);
  wire is_pre  = sel & (s_cmd == `SDC_CMD_PRECHARGE);
  wire is_ref  = sel & (s_cmd == `SDC_CMD_REFRESH);
  wire is_mrs  = sel & (s_cmd == `SDC_CMD_MODE_LOAD);

  // mode fields
  wire [2:0] bl_f   = MODE_WORD[`SDC_BL_MSB:`SDC_BL_LSB];
  wire       ord_f  = MODE_WORD[`SDC_ORDER_BIT];
  wire [2:0] lat_f  = MODE_WORD[`SDC_LAT_MSB:`SDC_LAT_LSB];
  wire       wsgl_f = MODE_WORD[`SDC_WSINGLE_BIT];
  // reserved latency codes fall back to three
  wire [1:0] lat    = (lat_f == `SDC_LAT_2) ? 2'h2 : 2'h3;

  // burst length in beats; single writes when write single bit set
  function [11:0] beats;
    input [2:0] code;
    begin
      case (code)
        `SDC_BL_1:    beats = 12'h001;
        `SDC_BL_2:    beats = 12'h002;
        `SDC_BL_4:    beats = 12'h004;
        `SDC_BL_8:    beats = 12'h008;
        `SDC_BL_PAGE: beats = 12'h800;
        default:      beats = 12'h001;
      endcase
    end
  endfunction

  // ************************************************************
  // burst state
  // ************************************************************
  reg [1:0]  state;                   // burst kind
  reg [11:0] left;                    // beats remaining
  reg [10:0] step;                    // beat index
  reg [10:0] start_col;               // start column
  reg [2:0]  cur_bl;                  // length code in use
  reg        cur_ord;                 // order in use
  reg        cur_ap;                  // auto precharge pending
  reg [1:0]  cur_bank;                // bank of burst
  reg [12:0] row_addr [0:3];          // open row per bank
  wire [10:0] gen_col;
  wire       new_col = is_rd | is_wr;
  wire [10:0] cmd_col = {s_addr[11], s_addr[9:0]};
  wire       burst_end = (state != ST_IDLE) & (left == 12'h001);

  sdc_col_gen u_col (
    .start_col       (start_col),
    .burst_len       (cur_bl),
    .burst_order_bit (cur_ord),
    .step            (step),
    .col             (gen_col)
  );

  // mode load, banks, refresh status
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      MODE_WORD    <= `SDC_MODE_RESET;
      LATENCY_BAD  <= 1'b0;
      ROW_OPEN     <= 4'h0;
      AUTO_REFRESH <= 1'b0;
      SELF_REFRESH <= 1'b0;
    end else begin
      AUTO_REFRESH <= is_ref & s_cke;
      if (is_ref & ~s_cke) begin
        SELF_REFRESH <= 1'b1;
      end else if (s_cke) begin
        SELF_REFRESH <= 1'b0;
      end
      if (is_mrs) begin
        MODE_WORD   <= s_addr[11:0];
        LATENCY_BAD <= (s_addr[6:4] != `SDC_LAT_2) & (s_addr[6:4] != `SDC_LAT_3);
      end
      if (is_act) begin
        ROW_OPEN[s_bank] <= 1'b1;
      end else if (is_pre) begin
        if (s_addr[`SDC_AP_BIT]) begin
          ROW_OPEN <= 4'h0;
        end else begin
          ROW_OPEN[s_bank] <= 1'b0;
        end
      end
      // auto precharge closes the row at burst end, not in full page
      if (burst_end & cur_ap & ~new_col & (cur_bl != `SDC_BL_PAGE)) begin
        ROW_OPEN[cur_bank] <= 1'b0;
      end
    end
  end

  // row store has no reset; valid only while its bank is open
  always @(posedge CORE_CLK) begin
    if (is_act) begin
      row_addr[s_bank] <= s_addr;
    end
  end

  // burst sequencer; a new read or write cuts the old burst short
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      left      <= 12'h000;
      step      <= 11'h000;
      start_col <= 11'h000;
      cur_bl    <= `SDC_BL_1;
      cur_ord   <= 1'b0;
      cur_ap    <= 1'b0;
      cur_bank  <= 2'h0;
    end else begin
      case (state)
        ST_IDLE, ST_READ, ST_WRITE: begin
          if (new_col) begin
            state     <= is_rd ? ST_READ : ST_WRITE;
            start_col <= cmd_col;
            step      <= 11'h000;
            cur_bank  <= s_bank;
            cur_ord   <= ord_f;
            cur_ap    <= s_addr[`SDC_AP_BIT];
            cur_bl    <= (is_wr & wsgl_f) ? `SDC_BL_1 : bl_f;
            left      <= (is_wr & wsgl_f) ? 12'h001 : beats(bl_f);
          end else if (is_term | burst_end) begin
            state <= ST_IDLE;
            left  <= 12'h000;
          end else if (state != ST_IDLE) begin
            left <= left - 12'h001;
            step <= step + 11'h001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // array strobes
  // ************************************************************
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ARR_READ    <= 1'b0;
      ARR_WRITE   <= 1'b0;
      ARR_BANK    <= 2'h0;
      ARR_ROW     <= 13'h0000;
      ARR_COL     <= 11'h000;
      ARR_WDATA   <= {DW{1'b0}};
      ARR_BYTE_EN <= {MW{1'b0}};
    end else begin
      ARR_READ  <= (state == ST_READ) & ~is_term & ~new_col;
      ARR_WRITE <= (state == ST_WRITE) & ~is_term & ~new_col;
      ARR_BANK  <= cur_bank;
      ARR_ROW   <= row_addr[cur_bank];
      ARR_COL   <= gen_col;
      ARR_WDATA <= s_dq;
      ARR_BYTE_EN <= ~s_dqm;
    end
  end

  // ************************************************************
  // read return: fifo then latency pipe to the pins
  // ************************************************************
  wire          fo_valid;
  wire [DW-1:0] fo_data;
  wire          fi_ready;
  reg  [3:0]    rd_pipe;              // beat marker; array round trip adds two
  reg  [MW-1:0] dqm_d1, dqm_d2;       // mask two clocks on
  wire          beat_due = (lat == 2'h2) ? rd_pipe[2] : rd_pipe[3];

  sdc_fifo #(.WIDTH(DW), .DEPTH(16), .AW(4)) u_fifo (
    .clk       (CORE_CLK),
    .rst_n     (rst_n),
    .in_valid  (ARR_RD_VALID),
    .in_ready  (fi_ready),
    .in_data   (ARR_RD_DATA),
    .out_valid (fo_valid),
    .out_ready (beat_due),
    .out_data  (fo_data)
  );

  // drive begins on the same edge that loads the beat into DQ_OUT
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rd_pipe      <= 4'h0;
      dqm_d1       <= {MW{1'b1}};
      dqm_d2       <= {MW{1'b1}};
      DQ_OUT       <= {DW{1'b0}};
      ARR_RD_READY <= 1'b0;
    end else begin
      ARR_RD_READY <= fi_ready;
      rd_pipe <= {rd_pipe[2:0], (state == ST_READ) & ~is_term & ~new_col};
      dqm_d1  <= s_dqm;
      dqm_d2  <= dqm_d1;
      if (beat_due & fo_valid) begin
        DQ_OUT <= fo_data;
      end
    end
  end

  // per-lane enable: drive only when beat due and mask low
  genvar g;
  generate
    for (g = 0; g < MW; g = g + 1) begin : g_lane
      always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
          DQ_OE[g*BW +: BW] <= {BW{1'b0}};
        end else begin
          DQ_OE[g*BW +: BW] <= {BW{beat_due & ~dqm_d2[g]}};
        end
      end
    end
  endgenerate
endmodule // sdc_top

//--- tb/sdc_array_model.sv
`timescale 1ns/1ns
// ******************************************
// array stand-in behind the read-data fifo
// ******************************************
module sdc_array_model (
  // clock
  input  wire        clk,
  // beat request from the block
  input  wire        rd,
  input  wire [10:0] col,
  // read data back to the block
  output reg         valid,
  output reg  [31:0] data
);
  // answer each beat on the next edge; data carries the column
  // so the bench can tell beats apart. between beats the data
  // is inverted so a stale word never passes for a fresh one
  always @(posedge clk) begin
    valid <= rd;
    data  <= rd ? {21'h0, col} : ~data;
  end
endmodule // sdc_array_model

//--- tb/sdc_top_sva.sv
`timescale 1ns/1ns
// ******************************************
// pin-level checker for the command block
// ******************************************
module sdc_top_sva #(
  parameter DW = 32
) (
  // clock and reset
  input wire          CORE_CLK,
  input wire          RESET_N,
  // command pins
  input wire          CS_N,
  input wire          RAS_N,
  input wire          CAS_N,
  input wire          WE_N,
  input wire          CKE,
  // watched outputs
  input wire [DW-1:0] DQ_OE,
  input wire          ARR_READ,
  input wire          ARR_WRITE,
  input wire [10:0]   ARR_COL,
  input wire          AUTO_REFRESH,
  input wire          SELF_REFRESH,
  input wire [11:0]   MODE_WORD,
  input wire          LATENCY_BAD
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  reg  [3:0] quiet;      // cycles since last read beat, saturating
  reg  [2:0] since_load; // cycles since mode-load pins, saturating
  wire       load_pins = !CS_N && !RAS_N && !CAS_N && !WE_N;
  // saturating counters keep long spans cheap for the tools
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      quiet <= 4'hF;
      since_load <= 3'h7;
    end else begin
      quiet <= ARR_READ ? 4'h0 : (quiet == 4'hF ? quiet : quiet + 4'h1);
      since_load <= load_pins ? 3'h0 : (since_load == 3'h7 ? since_load : since_load + 3'h1);
    end
  end
  a_refresh_excl: assert property (!(AUTO_REFRESH && SELF_REFRESH))
    else $error("auto and self refresh together");
  a_access_excl: assert property (!(ARR_READ && ARR_WRITE))
    else $error("read and write beat together");
  a_lane_oe: assert property (DQ_OE == {{8{DQ_OE[24]}}, {8{DQ_OE[16]}}, {8{DQ_OE[8]}}, {8{DQ_OE[0]}}})
    else $error("enable split inside a byte lane");
  a_idle_hiz: assert property (quiet == 4'hF |-> DQ_OE == 32'h0)
    else $error("data pins driven with no read");
  a_self_exit: assert property (CKE [*5] |-> !SELF_REFRESH)
    else $error("self refresh kept with gate high");
  a_latency_flag: assert property ($stable(MODE_WORD) |-> LATENCY_BAD == (MODE_WORD[6:4] != 3'h2 && MODE_WORD[6:4] != 3'h3))
    else $error("latency flag wrong");
  a_mode_cause: assert property ($changed(MODE_WORD) |-> since_load < 3'h6)
    else $error("mode word changed without a load");
  a_seq_eight: assert property (ARR_READ && $past(ARR_READ) && MODE_WORD[3:0] == 4'h3 |-> ARR_COL == {$past(ARR_COL[10:3]), $past(ARR_COL[2:0]) + 3'h1})
    else $error("sequential eight order broken");
  a_page_wrap: assert property (ARR_READ && $past(ARR_READ) && MODE_WORD[3:0] == 4'h7 |-> ARR_COL == $past(ARR_COL) + 11'h1)
    else $error("page burst step broken");
endmodule // sdc_top_sva
bind sdc_top sdc_top_sva #(.DW(DW)) u_sva (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .CKE(CKE),
  .DQ_OE(DQ_OE), .ARR_READ(ARR_READ), .ARR_WRITE(ARR_WRITE), .ARR_COL(ARR_COL), .AUTO_REFRESH(AUTO_REFRESH),
  .SELF_REFRESH(SELF_REFRESH), .MODE_WORD(MODE_WORD), .LATENCY_BAD(LATENCY_BAD)
);

//--- tb/test_sdram_command_and_burst_logic.sv
`timescale 1ns/1ns
`include "sdc_consts.vh"
// ******************************************
// self-checking bench for the command block
// ******************************************
module test_sdram_command_and_burst_logic;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         cs_n = 1'b1;
  reg  [2:0]  pins = 3'h7;   // row, column, write strobes
  reg         cke = 1'b1;
  reg  [12:0] addr = 13'h0;
  reg  [1:0]  bank = 2'h0;
  reg  [3:0]  dqm = 4'h0;
  reg  [31:0] dq_in = 32'h0;
  wire [31:0] dq_out, dq_oe, arr_data, arr_wdata;
  wire        arr_valid, arr_read, arr_write, auto_ref, self_ref, lat_bad, rd_ready;
  reg  [31:0] wd0;             // write data of the first write beat
  wire [1:0]  arr_bank;
  wire [12:0] arr_row;
  wire [10:0] arr_col;
  wire [3:0]  arr_be, row_open;
  wire [11:0] mode_word;
  reg  [15:0] lfsr = 16'h001A; // fixed seed
  reg  [29:0] rq[$], wq[$];    // beats seen: enable, bank, row, column
  reg  [12:0] op, row;
  reg  [10:0] c;
  reg  [3:0]  m;
  reg  [1:0]  b, bl;
  reg         o, ws;
  integer     i, k, n, t0, fail_count, samples_checked, cyc = 0, arf = 0, lat[4];
  always #5 clk = ~clk;
  sdc_top dut (.CORE_CLK(clk), .RESET_N(rst_n), .CS_N(cs_n), .RAS_N(pins[2]), .CAS_N(pins[1]), .WE_N(pins[0]),
    .CKE(cke), .ADDR(addr), .BANK_SELECT_LO(bank[0]), .BANK_SELECT_HI(bank[1]), .DQM(dqm), .DQ_IN(dq_in),
    .DQ_OUT(dq_out), .DQ_OE(dq_oe), .ARR_RD_VALID(arr_valid), .ARR_RD_READY(rd_ready), .ARR_RD_DATA(arr_data),
    .ARR_READ(arr_read), .ARR_WRITE(arr_write), .ARR_BANK(arr_bank), .ARR_ROW(arr_row), .ARR_COL(arr_col),
    .ARR_WDATA(arr_wdata), .ARR_BYTE_EN(arr_be), .ROW_OPEN(row_open), .AUTO_REFRESH(auto_ref),
    .SELF_REFRESH(self_ref), .MODE_WORD(mode_word), .LATENCY_BAD(lat_bad));
  sdc_array_model u_arr (.clk(clk), .rd(arr_read), .col(arr_col), .valid(arr_valid), .data(arr_data));
  // beat monitor: one queue entry per array access
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (arr_write && wq.size() == 0) wd0 <= arr_wdata;
    if (arr_read) rq.push_back({arr_be, arr_bank, arr_row, arr_col});
    if (arr_write) wq.push_back({arr_be, arr_bank, arr_row, arr_col});
    if (auto_ref) arf <= arf + 1;
  end
  function [15:0] nxt(input [15:0] v);
    nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // column of beat i: block bits kept, low bits counted or xored
  function [10:0] exp_col(input [10:0] s, input [2:0] l, input oi, input integer j);
    reg [10:0] mk;
    begin
      mk = (l == `SDC_BL_PAGE) ? 11'h7FF : ((11'h1 << l) - 11'h1);
      exp_col = (s & ~mk) | ((oi ? (s ^ j[10:0]) : (s + j[10:0])) & mk);
    end
  endfunction
  function [12:0] ca(input [10:0] cc, input ap);
    ca = {1'b0, cc[10], ap, cc[9:0]};
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // one command for one edge, then deselect; mask and data held after
  task cmd(input [2:0] cd, input [12:0] a, input [1:0] ba, input [3:0] mq);
    begin
      @(posedge clk);
      cs_n <= 1'b0;
      pins <= cd;
      addr <= a;
      bank <= ba;
      dqm <= mq;
      dq_in <= {lfsr, ~lfsr};
      t0 = cyc;
      @(posedge clk);
      cs_n <= 1'b1;
    end
  endtask
  // waits end on a falling edge so outputs are settled
  task idle(input integer cnt);
    repeat (cnt) @(negedge clk);
  endtask
  task done(input string nm);
    $display("test %s done", nm);
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // watchdog: the tests need about a thousand cycles
  initial begin
    #200000;
    fail_count = fail_count + 1;
    conclude;
  end
  initial begin
    fail_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    idle(4);
    chk("mode reset", 12'h020, mode_word);
    chk("rows idle", 0, row_open);
    chk("data idle", 0, dq_oe);
    chk("fifo room", 1, rd_ready);
    done("reset");
    // lengths one to eight, both orders and both write modes with random place
    for (i = 0; i < 16; i = i + 1) begin
      bl = i[1:0];
      o = i[2];
      ws = i[3];
      lfsr = nxt(lfsr);
      b = lfsr[1:0];
      row = lfsr[12:0];
      lfsr = nxt(lfsr);
      c = lfsr[10:0];
      m = lfsr[14:11];
      op = {3'h0, ws, 2'h0, `SDC_LAT_2, o, 1'b0, bl};
      cmd(`SDC_CMD_MODE_LOAD, op, 2'h0, 4'h0);
      idle(6);
      chk("mode word", op[11:0], mode_word);
      cmd(`SDC_CMD_ACTIVATE, row, b, 4'h0);
      idle(4);
      rq.delete();
      wq.delete();
      cmd(`SDC_CMD_READ, ca(c, 1'b0), b, 4'h0);
      idle(14);
      cmd(`SDC_CMD_WRITE, ca(c, 1'b0), b, m);
      idle(14);
      n = 1 << bl;
      chk("read beats", n, rq.size());
      for (k = 0; k < n && k < rq.size(); k = k + 1) chk("read col", {b, row, exp_col(c, {1'b0, bl}, o, k)}, rq[k][25:0]);
      chk("write beats", ws ? 1 : n, wq.size());
      chk("write first", {~m, b, row, c}, wq[0]);
      chk("write data", {lfsr, ~lfsr}, wd0);
      cmd(`SDC_CMD_PRECHARGE, 13'h0400, 2'h0, 4'h0);
      idle(4);
      chk("all closed", 0, row_open);
    end
    done("bursts");
    // both latencies, low lane masked
    for (i = 2; i < 4; i = i + 1) begin
      cmd(`SDC_CMD_MODE_LOAD, {6'h0, i[2:0], 4'h0}, 2'h0, 4'h0);
      idle(6);
      cmd(`SDC_CMD_ACTIVATE, 13'h0011, 2'h1, 4'h0);
      idle(4);
      cmd(`SDC_CMD_READ, ca(11'h5A3, 1'b0), 2'h1, 4'h1);
      for (n = 0; dq_oe == 32'h0 && n < 40; n = n + 1) @(negedge clk);
      lat[i] = cyc - t0;
      chk("masked lane", 32'hFFFFFF00, dq_oe);
      chk("read data", 24'h000005, dq_out[31:8]);
      idle(8);
      cmd(`SDC_CMD_PRECHARGE, 13'h0400, 2'h0, 4'h0);
      idle(4);
    end
    chk("latency step", 1, lat[3] - lat[2]);
    done("latency");
    // deselect and no-operation in mid-burst
    cmd(`SDC_CMD_MODE_LOAD, {6'h0, `SDC_LAT_2, 4'h3}, 2'h0, 4'h0);
    idle(6);
    cmd(`SDC_CMD_ACTIVATE, 13'h0022, 2'h2, 4'h0);
    idle(4);
    rq.delete();
    wq.delete();
    cmd(`SDC_CMD_READ, ca(11'h010, 1'b0), 2'h2, 4'h0);
    pins <= `SDC_CMD_WRITE;
    idle(3);
    @(posedge clk);
    cs_n <= 1'b0;
    pins <= `SDC_CMD_NOP;
    idle(14);
    chk("beats kept", 8, rq.size());
    chk("no write", 0, wq.size());
    chk("row kept", 4'h4, row_open);
    cmd(`SDC_CMD_ACTIVATE, 13'h0033, 2'h1, 4'h0);
    idle(4);
    cmd(`SDC_CMD_PRECHARGE, 13'h0000, 2'h2, 4'h0);
    idle(4);
    chk("one closed", 4'h2, row_open);
    cmd(`SDC_CMD_READ, ca(11'h7F0, 1'b1), 2'h1, 4'h0);
    idle(16);
    chk("auto closed", 0, row_open);
    done("select");
    // full page from near the top, cut short
    cmd(`SDC_CMD_MODE_LOAD, {6'h0, `SDC_LAT_2, 4'h7}, 2'h0, 4'h0);
    idle(6);
    cmd(`SDC_CMD_ACTIVATE, 13'h1ABC, 2'h3, 4'h0);
    idle(4);
    rq.delete();
    cmd(`SDC_CMD_READ, ca(11'h7FC, 1'b0), 2'h3, 4'h0);
    idle(8);
    cmd(`SDC_CMD_TERMINATE, 13'h0, 2'h0, 4'h0);
    idle(12);
    for (k = 0; k < 6; k = k + 1) chk("page col", exp_col(11'h7FC, 3'h7, 1'b0, k), rq[k][10:0]);
    chk("stopped", 1, rq.size() < 20);
    cmd(`SDC_CMD_PRECHARGE, 13'h0400, 2'h0, 4'h0);
    idle(4);
    done("page");
    // refresh kinds and a reserved latency
    cmd(`SDC_CMD_REFRESH, 13'h0, 2'h0, 4'h0);
    idle(6);
    chk("auto refresh", 1, arf);
    @(posedge clk);
    cke <= 1'b0;
    cmd(`SDC_CMD_REFRESH, 13'h0, 2'h0, 4'h0);
    idle(6);
    chk("self refresh", 1, self_ref);
    @(posedge clk);
    cke <= 1'b1;
    idle(8);
    chk("self exit", 0, self_ref);
    cmd(`SDC_CMD_MODE_LOAD, 13'h0050, 2'h0, 4'h0);
    idle(6);
    chk("latency flag", 1, lat_bad);
    done("refresh");
    conclude;
  end
endmodule // test_sdram_command_and_burst_logic
